// >>> rtl/mcs_sequencer.sv
// Function
// - Nine registered 1K stores share the next-address bus and clock.
// - Dispatch store decodes requests and drives routine start address.
// - Edge after dispatch hands the bus to the next-address store.
// - Next-address store yields each step address every clock edge.
// - Final routine step asserts return, giving bus back to dispatch.
// - Low address bit can follow any of 22 conditions via three muxes.
// - Branch-select store picks a condition per step: two-way branching.
// - Seven control stores each give eight control outputs per step.
// - One control output forms the top next-address bit.
// - With no request pending, the sequencer enters instruction fetch.
// - Fetch copies program counter into loadable firmware address latch.
// - Firmware read strobe then opcode load puts word on address bus.
// - An 8-bit arithmetic unit holds registers including the counter.
// - Host register pair accesses are recognised and serviced.
// - With auto-boot, accesses to either boot window start bootstrap.
// - Sequencer raises host interrupt requests and runs vector transfer.
// - DMA uses block mode if memory supports it; flags transfer errors.
// - Disc transfers move words between the disc FIFO and cache.
// - Host cycles: data, read-modify-write, interrupt and 22-bit DMA.
// - A recognised interrupt acknowledge starts the vector routine.
// - A DMA grant starts the microcode DMA transfer routine.
`timescale 1ns/100ps
`default_nettype none
module mcs_sequencer #(
   parameter int FIFO_DEPTH = mcs_pkg::FIFO_DEPTH
) (
   input  wire logic                                      clk_sys,
   input  wire logic                                      rst_b,
   input  wire logic                                      interrupt_ack_seen,
   input  wire logic                                      transfer_grant_seen,
   input  wire logic                                      refresh_req,
   input  wire logic                                      host_ip_access,
   input  wire logic                                      host_sa_access,
   input  wire logic                                      boot_access,
   input  wire logic                                      auto_boot_en,
   input  wire logic                                      disc_req,
   input  wire logic [mcs_pkg::COND_COUNT-1:0]            cond_in,
   input  wire logic                                      block_mode_ok,
   input  wire logic                                      mem_parity_err,
   input  wire logic                                      bus_timeout,
   input  wire logic [mcs_pkg::FW_DATA_W-1:0]             fw_data,
   input  wire logic [mcs_pkg::ALU_W-1:0]                 alu_data_in,
   input  wire logic                                      disc_in_valid,
   output var  logic                                      disc_in_ready,
   input  wire logic [mcs_pkg::FIFO_W-1:0]                disc_in_data,
   input  wire logic                                      cache_ready,
   output var  logic                                      cache_valid_q,
   output var  logic [mcs_pkg::FIFO_W-1:0]                cache_data_q,
   output var  logic [mcs_pkg::ADDR_W-1:0]                next_addr_q,
   output var  logic [mcs_pkg::CTRL_STORES*mcs_pkg::CTRL_W-1:0] ctrl_q,
   output var  logic [mcs_pkg::FW_ADDR_W-1:0]             fw_addr_q,
   output var  logic                                      firmware_read_strobe_q,
   output var  logic                                      opcode_load_q,
   output var  logic                                      irq_q,
   output var  logic                                      block_mode_q,
   output var  logic                                      dma_err_q,
   output var  logic [mcs_pkg::ALU_W-1:0]                 pc_q
);
   import mcs_pkg::*;

   // ************************************************************
   // Microcode stores.
   // ************************************************************
   logic [ADDR_W-1:0]             bus_addr;
   logic [ADDR_W-2:0]             nstore_q;
   logic [SEL_W-1:0]              bsel_q;
   logic [CTRL_STORES*CTRL_W-1:0] cstore_q;
   logic [CTRL_W-1:0]             upper;
   mcs_owner_t                    owner_q;
   logic [ADDR_W-1:0]             addr_q;

   // Next-address store: low nine bits of successor.
   mcs_rom #(.DEPTH(STORE_DEPTH), .AW(ADDR_W), .DW(ADDR_W-1)) u_nstore (
      .clk_sys (clk_sys),
      .addr    (bus_addr),
      .data_q  (nstore_q)
   );

   // Branch-select store picks a condition for each step.
   mcs_rom #(.DEPTH(STORE_DEPTH), .AW(ADDR_W), .DW(SEL_W)) u_bstore (
      .clk_sys (clk_sys),
      .addr    (bus_addr),
      .data_q  (bsel_q)
   );

   // Seven control stores of eight outputs each, one generate loop.
   for (genvar g = 0; g < CTRL_STORES; g++) begin : g_ctrl
      mcs_rom #(.DEPTH(STORE_DEPTH), .AW(ADDR_W), .DW(CTRL_W)) u_cstore (
         .clk_sys (clk_sys),
         .addr    (bus_addr),
         .data_q  (cstore_q[g*CTRL_W +: CTRL_W])
      );
   end

   // Store three carries the sequencing control bits.
   assign upper = cstore_q[UPPER_STORE*CTRL_W +: CTRL_W];

   // ************************************************************
   // Condition selection through three 8-input multiplexers.
   // ************************************************************
   logic [COND_COUNT-1:0]           cond_q;
   logic [MUX_COUNT*MUX_INPUTS-1:0] cond_pad;
   logic [MUX_COUNT-1:0]            mux_out;
   logic                            branch_bit;

   // Conditions are registered on the system clock.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cond_q <= '0;
      end else begin
         cond_q <= cond_in;
      end
   end

   // Unused inputs of the last multiplexer read as zero.
   assign cond_pad = {(MUX_COUNT*MUX_INPUTS-COND_COUNT)'(0), cond_q};

   // One multiplexer per group of eight inputs.
   for (genvar m = 0; m < MUX_COUNT; m++) begin : g_mux
      assign mux_out[m] = cond_pad[m*MUX_INPUTS + 32'(bsel_q[2:0])];
   end

   // Upper select bits choose the multiplexer; selects 24 up give zero.
   always_comb begin
      case (bsel_q[4:3])
         2'b00:   branch_bit = mux_out[0];
         2'b01:   branch_bit = mux_out[1];
         2'b10:   branch_bit = mux_out[2];
         default: branch_bit = 1'b0;
      endcase
   end

   // ************************************************************
   // Dispatch store: fixed priority request decode.
   // ************************************************************
   logic [REQ_COUNT-1:0] req;
   logic                 any_req;
   logic [ADDR_W-1:0]    start_addr;
   logic                 ret;

   // Host data, interrupt and transfer cycles arrive as requests.
   assign req[REQ_INT_ACK]   = interrupt_ack_seen;
   assign req[REQ_DMA_GRANT] = transfer_grant_seen;
   assign req[REQ_REFRESH]   = refresh_req;
   assign req[REQ_HOST_IP]   = host_ip_access;
   assign req[REQ_HOST_SA]   = host_sa_access;
   assign req[REQ_BOOT]      = boot_access && auto_boot_en;
   assign req[REQ_DISC]      = disc_req;
   assign req[REQ_SPARE]     = 1'b0;
   assign any_req            = |req;
   assign ret                = upper[CW_RETURN];

   // Lowest index wins; routines start sixteen words apart.
   always_comb begin
      start_addr = FETCH_ENT;
      for (int i = REQ_COUNT - 1; i >= 0; i--) begin
         if (req[i]) begin
            start_addr = {1'b0, 5'(i), 4'h0};
         end
      end
   end

   // ************************************************************
   // Next-address bus ownership.
   // ************************************************************
   // Bus value: dispatch drives low lines, routine uses stores, fetch
   // places the firmware word. In a routine the top bit comes from the upper store.
   always_comb begin
      case (owner_q)
         // Dispatch store drives the start address.
         MCS_DISPATCH: bus_addr = start_addr;
         // Top bit from the upper store, low bit from the condition.
         MCS_ROUTINE:  bus_addr = {upper[CW_TOP_BIT],
                                   nstore_q[ADDR_W-2:1], branch_bit};
         MCS_FETCH:    bus_addr = {2'b01, fw_data};
         default:      bus_addr = ADDR_RST;
      endcase
   end

   // Dispatch owns the bus after reset.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         owner_q <= MCS_DISPATCH;
      end else begin
         case (owner_q)
            MCS_DISPATCH: owner_q <= MCS_ROUTINE;
            MCS_ROUTINE: begin
               if (ret) begin
                  owner_q <= MCS_DISPATCH;
               end else if (upper[CW_OPC_LOAD]) begin
                  owner_q <= MCS_FETCH;
               end
            end
            MCS_FETCH:    owner_q <= MCS_ROUTINE;
            default:      owner_q <= MCS_DISPATCH;
         endcase
      end
   end

   // The current bus address, made visible each edge.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         addr_q <= ADDR_RST;
      end else begin
         addr_q <= bus_addr;
      end
   end

   // The bus address leaves the block straight from its register.
   assign next_addr_q = addr_q;

   // ************************************************************
   // Arithmetic unit registers and firmware fetch.
   // ************************************************************
   logic [ALU_W-1:0] regs_q [8];

   // Eight-bit register set; entry zero is the program counter.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         for (int r = 0; r < 8; r++) begin
            regs_q[r] <= '0;
         end
      end else if (upper[CW_PC_LOAD]) begin
         regs_q[cstore_q[2:0]] <= alu_data_in;
      end else if (upper[CW_OPC_LOAD]) begin
         regs_q[0] <= regs_q[0] + ALU_W'(1);
      end
   end

   // Entry zero of the register set is the program counter.
   assign pc_q = regs_q[0];

   // Address latch loads from the counter, then strobes.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         fw_addr_q              <= FWA_RST;
         firmware_read_strobe_q <= 1'b0;
         opcode_load_q          <= 1'b0;
      end else begin
         if (upper[CW_PC_LOAD] && owner_q == MCS_ROUTINE) begin
            fw_addr_q <= FW_ADDR_W'(regs_q[0]);
         end
         firmware_read_strobe_q <= upper[CW_FW_READ];
         opcode_load_q          <= upper[CW_OPC_LOAD];
      end
   end

   // Control outputs, interrupt and DMA mode.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         ctrl_q       <= '0;
         irq_q        <= 1'b0;
         block_mode_q <= 1'b0;
         dma_err_q    <= 1'b0;
      end else begin
         ctrl_q       <= cstore_q;
         irq_q        <= upper[CW_IRQ];
         if (transfer_grant_seen) begin
            block_mode_q <= block_mode_ok;
         end
         dma_err_q    <= mem_parity_err || bus_timeout;
      end
   end

   // ************************************************************
   // Disc FIFO to cache path.
   // ************************************************************
   logic              f_valid;
   logic              f_ready;
   logic [FIFO_W-1:0] f_data;

   // Words from the disc buffer are held until the cache accepts.
   mcs_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .in_valid  (disc_in_valid),
      .in_ready  (disc_in_ready),
      .in_data   (disc_in_data),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   // The output stage takes a word when empty or being drained.
   assign f_ready = !cache_valid_q || cache_ready;

   // Output stage register toward the cache.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         cache_valid_q <= 1'b0;
         cache_data_q  <= '0;
      end else if (f_ready) begin
         cache_valid_q <= f_valid;
         cache_data_q  <= f_data;
      end
   end

endmodule
`default_nettype wire

// >>> rtl/mcs_pkg.sv
`default_nettype none
package mcs_pkg;

   // ************************************************************
   // Store geometry and field positions.
   // ************************************************************
   localparam int STORE_DEPTH    = 1024;
   localparam int ADDR_W         = 10;
   localparam int CTRL_STORES    = 7;
   localparam int CTRL_W         = 8;
   localparam int COND_COUNT     = 22;
   localparam int MUX_INPUTS     = 8;
   localparam int MUX_COUNT      = 3;
   localparam int SEL_W          = 5;
   localparam int ALU_W          = 8;
   localparam int FW_ADDR_W      = 20;
   localparam int FW_DATA_W      = 8;
   localparam int FIFO_W         = 16;
   localparam int FIFO_DEPTH     = 16;
   localparam int REQ_COUNT      = 8;
   localparam int HOST_ADDR_W    = 22;

   // Bit positions inside the control word of store 3 (the upper-bit store).
   localparam int CW_TOP_BIT     = 0;
   localparam int CW_RETURN      = 1;
   localparam int CW_FW_READ     = 2;
   localparam int CW_OPC_LOAD    = 3;
   localparam int CW_PC_LOAD     = 4;
   localparam int CW_FIFO_POP    = 5;
   localparam int CW_FIFO_PUSH   = 6;
   localparam int CW_IRQ         = 7;
   localparam int UPPER_STORE    = 3;

   // Request inputs to the dispatch store, index equals priority.
   localparam int REQ_INT_ACK    = 0;
   localparam int REQ_DMA_GRANT  = 1;
   localparam int REQ_REFRESH    = 2;
   localparam int REQ_HOST_IP    = 3;
   localparam int REQ_HOST_SA    = 4;
   localparam int REQ_BOOT       = 5;
   localparam int REQ_DISC       = 6;
   localparam int REQ_SPARE      = 7;

   // Reset values and the fetch entry address.
   localparam logic [ADDR_W-1:0]    ADDR_RST  = 10'h000;
   localparam logic [ADDR_W-1:0]    FETCH_ENT = 10'h0fe;
   localparam logic [FW_ADDR_W-1:0] FWA_RST   = 20'h00000;

   typedef enum logic [1:0] {
      MCS_DISPATCH = 2'b00,
      MCS_ROUTINE  = 2'b01,
      MCS_FETCH    = 2'b11
   } mcs_owner_t;

   typedef struct packed {
      logic [CTRL_STORES*CTRL_W-1:0] ctrl;
      logic [SEL_W-1:0]              sel;
   } mcs_uword_t;

   typedef struct packed {
      logic                   valid;
      logic [FIFO_W-1:0]      data;
   } mcs_word_t;

endpackage
`default_nettype wire

// >>> rtl/mcs_rom.sv
`timescale 1ns/100ps
`default_nettype none
// Registered read-only store; contents are loaded by the array initialiser.
module mcs_rom #(
   parameter int DEPTH = 1024,
   parameter int AW    = 10,
   parameter int DW    = 8
) (
   input  wire logic          clk_sys,
   input  wire logic [AW-1:0] addr,
   output var  logic [DW-1:0] data_q
);

   logic [DW-1:0] mem [DEPTH];

   // Default microcode image is all zero, replaced per build.
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         mem[i] = '0;
      end
   end

   // The output is registered on every system clock edge.
   always_ff @(posedge clk_sys) begin
      data_q <= mem[addr];
   end

endmodule
`default_nettype wire

// >>> rtl/mcs_fifo.sv
`timescale 1ns/100ps
`default_nettype none
// Synchronous FIFO between the disc word source and the cache port.
module mcs_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 16
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_b,
   input  wire logic         in_valid,
   output var  logic         in_ready,
   input  wire logic [W-1:0] in_data,
   output var  logic         out_valid,
   input  wire logic         out_ready,
   output var  logic [W-1:0] out_data
);

   localparam int PW = $clog2(DEPTH);

   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] wr_q;
   logic [PW-1:0] rd_q;
   logic [PW:0]   cnt_q;
   logic          push;
   logic          pop;

   // Full and empty follow the occupancy count.
   assign in_ready  = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Storage write.
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // Pointers and count.
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + PW'(1);
         end
         if (pop) begin
            rd_q <= rd_q + PW'(1);
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

endmodule
`default_nettype wire

// >>> test/mcs_seq_props.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Port-level checks of the sequencer.
// ************************************************************
module mcs_seq_props
   import mcs_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic                clk_sys,
   input wire logic                rst_b,
   input wire logic                interrupt_ack_seen,
   input wire logic                transfer_grant_seen,
   input wire logic                refresh_req,
   input wire logic                host_ip_access,
   input wire logic                host_sa_access,
   input wire logic                boot_access,
   input wire logic                auto_boot_en,
   input wire logic                disc_req,
   input wire logic                disc_in_ready,
   input wire logic                cache_ready,
   input wire logic                cache_valid_q,
   input wire logic [FIFO_W-1:0]   cache_data_q,
   input wire logic [ADDR_W-1:0]   next_addr_q,
   input wire logic                firmware_read_strobe_q,
   input wire logic                opcode_load_q,
   input wire logic                irq_q
);
   logic any_req;

   // A boot access only counts when auto-boot is on.
   assign any_req = interrupt_ack_seen | transfer_grant_seen | refresh_req
                  | host_ip_access | host_sa_access | disc_req
                  | (boot_access & auto_boot_en);

   a_reset_clear: assert property (@(posedge clk_sys)
      !rst_b |=> next_addr_q == 10'h000 && !irq_q && !opcode_load_q
                 && !firmware_read_strobe_q)
      else $error("outputs not cleared by reset");
   a_fetch_idle: assert property (@(posedge clk_sys)
      (!rst_b ##1 rst_b && !any_req) |=> next_addr_q == FETCH_ENT)
      else $error("idle start did not enter fetch");
   a_ack_first: assert property (@(posedge clk_sys)
      (!rst_b ##1 rst_b && interrupt_ack_seen) |=> next_addr_q == 10'h000)
      else $error("acknowledge did not win dispatch");
   a_grant_start: assert property (@(posedge clk_sys)
      (!rst_b ##1 rst_b && !interrupt_ack_seen && transfer_grant_seen)
      |=> next_addr_q == 10'h010)
      else $error("grant did not start its routine");
   a_boot_gate: assert property (@(posedge clk_sys)
      (!rst_b ##1 rst_b && boot_access && !auto_boot_en && !any_req)
      |=> next_addr_q == FETCH_ENT)
      else $error("boot access taken while auto-boot off");
   a_strobe_order: assert property (@(posedge clk_sys)
      disable iff (!rst_b) $rose(opcode_load_q)
      |-> $past(firmware_read_strobe_q) || $past(firmware_read_strobe_q, 2))
      else $error("opcode load without firmware read");
   a_ready_empty: assert property (@(posedge clk_sys)
      $rose(rst_b) |-> disc_in_ready)
      else $error("empty buffer refuses words");
   a_cache_hold: assert property (@(posedge clk_sys)
      disable iff (!rst_b) cache_valid_q && !cache_ready
      |=> cache_valid_q && $stable(cache_data_q))
      else $error("cache word dropped while stalled");

   // Main scenarios reached.
   c_drain: cover property (@(posedge clk_sys) cache_valid_q && cache_ready);
   c_full: cover property (@(posedge clk_sys) rst_b && !disc_in_ready);
   c_fetch: cover property (@(posedge clk_sys) next_addr_q == FETCH_ENT);
endmodule

bind mcs_sequencer mcs_seq_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
   .clk_sys(clk_sys), .rst_b(rst_b),
   .interrupt_ack_seen(interrupt_ack_seen),
   .transfer_grant_seen(transfer_grant_seen), .refresh_req(refresh_req),
   .host_ip_access(host_ip_access), .host_sa_access(host_sa_access),
   .boot_access(boot_access), .auto_boot_en(auto_boot_en),
   .disc_req(disc_req), .disc_in_ready(disc_in_ready),
   .cache_ready(cache_ready), .cache_valid_q(cache_valid_q),
   .cache_data_q(cache_data_q), .next_addr_q(next_addr_q),
   .firmware_read_strobe_q(firmware_read_strobe_q),
   .opcode_load_q(opcode_load_q), .irq_q(irq_q));
`default_nettype wire

// >>> test/mcs_cache_sink.sv
`timescale 1ns/100ps
`default_nettype none
// Cache-side sink: accepts words at half rate and can stall fully.
module mcs_cache_sink (
   input wire logic        clk_sys,
   input wire logic        rst_b,
   input wire logic        stall,
   input wire logic        cache_valid_q,
   input wire logic [15:0] cache_data_q,
   output var logic        cache_ready
);
   logic [15:0] got [$];
   logic        slow_q;

   // Words are taken only at an edge where valid and ready meet.
   always @(posedge clk_sys) begin
      if (!rst_b) begin
         cache_ready <= 1'b0;
         slow_q <= 1'b0;
         got.delete();
      end else begin
         if (cache_valid_q && cache_ready)
            got.push_back(cache_data_q);
         slow_q <= !slow_q;
         cache_ready <= !stall && slow_q;
      end
   end
endmodule
`default_nettype wire

// >>> test/mcs_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module mcs_sequencer_bench;
   import mcs_pkg::*;
   logic              clk_sys, rst_b, auto_boot_en, disc_in_valid, stall;
   logic              block_ok, par_err, tmo;
   logic [6:0]        req;
   logic [21:0]       cond;
   logic [7:0]        fw, alu;
   logic [15:0]       din;
   wire logic         disc_in_ready, cache_ready, cache_valid_q;
   wire logic [15:0]  cache_data_q;
   wire logic [9:0]   next_addr_q;
   wire logic [55:0]  ctrl_q;
   wire logic [19:0]  fw_addr_q;
   wire logic [7:0]   pc_q;
   wire logic         firmware_read_strobe_q, opcode_load_q, irq_q;
   wire logic         block_mode_q, dma_err_q;
   int                err_count, total_checks;

   mcs_sequencer #(.FIFO_DEPTH(16)) dut (
      .clk_sys(clk_sys), .rst_b(rst_b),
      .interrupt_ack_seen(req[REQ_INT_ACK]),
      .transfer_grant_seen(req[REQ_DMA_GRANT]),
      .refresh_req(req[REQ_REFRESH]), .host_ip_access(req[REQ_HOST_IP]),
      .host_sa_access(req[REQ_HOST_SA]), .boot_access(req[REQ_BOOT]),
      .auto_boot_en(auto_boot_en), .disc_req(req[REQ_DISC]),
      .cond_in(cond), .block_mode_ok(block_ok), .mem_parity_err(par_err),
      .bus_timeout(tmo), .fw_data(fw), .alu_data_in(alu),
      .disc_in_valid(disc_in_valid), .disc_in_ready(disc_in_ready),
      .disc_in_data(din), .cache_ready(cache_ready),
      .cache_valid_q(cache_valid_q), .cache_data_q(cache_data_q),
      .next_addr_q(next_addr_q), .ctrl_q(ctrl_q), .fw_addr_q(fw_addr_q),
      .firmware_read_strobe_q(firmware_read_strobe_q),
      .opcode_load_q(opcode_load_q), .irq_q(irq_q),
      .block_mode_q(block_mode_q), .dma_err_q(dma_err_q), .pc_q(pc_q));

   mcs_cache_sink sink (
      .clk_sys(clk_sys), .rst_b(rst_b), .stall(stall),
      .cache_valid_q(cache_valid_q), .cache_data_q(cache_data_q),
      .cache_ready(cache_ready));

   // Free-running system clock.
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // Compares one value and counts the result.
   task chk(string name, logic [15:0] seen, logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Prints the counts and the verdict, then stops.
   task test_done;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Resets, releases with requests present, waits for the dispatch.
   task start_up(logic [6:0] r, logic ab, logic [9:0] exp);
      int k;
      rst_b = 1'b0;
      req = 7'h00;
      repeat (8) @(posedge clk_sys);
      #2;
      chk("reset addr", 16'(next_addr_q), 16'h0000);
      rst_b = 1'b1;
      req = r;
      auto_boot_en = ab;
      cond = {r, 15'h5a3c};
      for (k = 0; k < 4; k++) begin
         @(posedge clk_sys);
         #2;
         if (next_addr_q === exp)
            break;
      end
      chk("dispatch addr", 16'(next_addr_q), 16'(exp));
   endtask

   // Every request wins over all those of lower priority.
   task t_priority;
      for (int i = 0; i < 7; i++)
         start_up(7'h7f << i, 1'b1, 10'(i * 16));
   endtask

   // Boot access alone is refused without auto-boot; idle fetches.
   task t_boot_gate;
      start_up(7'h20, 1'b0, FETCH_ENT);
      start_up(7'h20, 1'b1, 10'h050);
      start_up(7'h00, 1'b1, FETCH_ENT);
   endtask

   // A condition seen at one edge picks the odd successor at the next.
   task t_branch;
      start_up(7'h01, 1'b0, 10'h000);
      cond = 22'h000001;
      repeat (2) @(posedge clk_sys);
      #2;
      chk("odd successor", 16'(next_addr_q), 16'h0001);
      cond = 22'h3ffffe;
      repeat (2) @(posedge clk_sys);
      #2;
      chk("even successor", 16'(next_addr_q), 16'h0000);
   endtask

   // Grant latches block capability; errors show one edge later.
   task t_dma;
      block_ok = 1'b1;
      start_up(7'h02, 1'b0, 10'h010);
      chk("block mode", 16'(block_mode_q), 16'h0001);
      req = 7'h00;
      block_ok = 1'b0;
      par_err = 1'b1;
      @(posedge clk_sys);
      #2;
      chk("block mode held", 16'(block_mode_q), 16'h0001);
      chk("parity error", 16'(dma_err_q), 16'h0001);
      req = 7'h02;
      par_err = 1'b0;
      tmo = 1'b1;
      @(posedge clk_sys);
      #2;
      chk("burst mode", 16'(block_mode_q), 16'h0000);
      chk("timeout error", 16'(dma_err_q), 16'h0001);
      tmo = 1'b0;
      @(posedge clk_sys);
      #2;
      chk("error cleared", 16'(dma_err_q), 16'h0000);
      // Blank store images leave every control output low.
      chk("interrupt request", 16'(irq_q), 16'h0000);
      chk("read strobe", 16'(firmware_read_strobe_q), 16'h0000);
      chk("opcode load", 16'(opcode_load_q), 16'h0000);
      chk("control word", 16'(|ctrl_q), 16'h0000);
      chk("program counter", 16'(pc_q), 16'h0000);
      chk("firmware address", 16'(|fw_addr_q), 16'h0000);
   endtask

   // Fills the buffer against a stalled sink, then drains it in order.
   task t_fifo;
      int pushed;
      int k;
      stall = 1'b1;
      start_up(7'h00, 1'b0, FETCH_ENT);
      pushed = 0;
      for (k = 0; k < 24; k++) begin
         if (!disc_in_ready)
            break;
         din = 16'ha500 + 16'(pushed);
         disc_in_valid = 1'b1;
         @(posedge clk_sys);
         #2;
         pushed++;
      end
      disc_in_valid = 1'b0;
      // The output stage holds one word beyond the buffer's depth.
      chk("fill count", 16'(pushed), 16'(FIFO_DEPTH + 1));
      stall = 1'b0;
      for (k = 0; k < 200 && sink.got.size() < pushed; k++)
         @(posedge clk_sys);
      #2;
      chk("drained count", 16'(sink.got.size()), 16'(pushed));
      foreach (sink.got[i])
         chk("drained word", sink.got[i], 16'ha500 + 16'(i));
   endtask

   // Main sequence.
   initial begin
      rst_b = 1'b0;
      req = 7'h00;
      auto_boot_en = 1'b0;
      disc_in_valid = 1'b0;
      stall = 1'b1;
      cond = 22'h000000;
      block_ok = 1'b1;
      par_err = 1'b0;
      tmo = 1'b0;
      fw = 8'h3c;
      alu = 8'h81;
      din = 16'h0000;
      err_count = 0;
      total_checks = 0;
      t_priority;
      t_boot_gate;
      t_branch;
      t_dma;
      t_fifo;
      test_done;
   end

   // Cuts a hang short.
   initial begin
      repeat (5000) @(posedge clk_sys);
      err_count++;
      $display("unexpected watchdog expiry");
      test_done;
   end
endmodule
`default_nettype wire
